// ### sadc_pkg.sv
// sadc_pkg: offsets, field positions and reset values of the slope
// converter control block; shared by the control top and its timer.
package sadc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TMR_W  = 16;

    // register byte offsets
    localparam logic [7:0] OFF_CHAN  = 8'h00;
    localparam logic [7:0] OFF_SRC   = 8'h04;
    localparam logic [7:0] OFF_PWR   = 8'h08;
    localparam logic [7:0] OFF_TMR_H = 8'h0c;
    localparam logic [7:0] OFF_TMR_L = 8'h10;
    localparam logic [7:0] OFF_CAP   = 8'h14;
    localparam logic [7:0] OFF_STAT  = 8'h18;

    // reset values
    localparam logic [7:0] CHAN_RST = 8'h02;
    localparam logic [7:0] SRC_RST  = 8'h00;
    localparam logic [7:0] PWR_RST  = 8'h3f;

    // read masks: unimplemented bits read as zero
    localparam logic [7:0] CHAN_RMASK = 8'hf7;
    localparam logic [7:0] PWR_RMASK  = 8'hbf;

    // channel control fields
    localparam int SEL_LSB  = 4;
    localparam int MUXOE_B  = 2;
    localparam int HOLD_B   = 1;
    localparam int ZERO_B   = 0;
    // source and pin configuration fields
    localparam int STEP_LSB = 4;
    localparam int HIGRP_LSB = 2;
    localparam int LOGRP_LSB = 0;
    // power control fields
    localparam int REFPD_B  = 5;
    localparam int OSCD_B   = 3;
    localparam int CONVPD_B = 0;
    // status fields
    localparam int CAPF_B   = 0;
    localparam int OVFF_B   = 1;

    // input select and current step codes with special meaning
    localparam logic [3:0] SEL_BANDGAP = 4'h4;
    localparam logic [3:0] SEL_UPPER   = 4'h5;
    localparam logic [3:0] SEL_LOWER   = 4'h6;
    localparam logic [3:0] STEP_OFF    = 4'h0;

    // pin kind codes per group of four
    localparam logic [1:0] KIND_ALL_ANALOG = 2'h0;
    localparam logic [1:0] KIND_ONE_DIG    = 2'h1;
    localparam logic [1:0] KIND_TWO_DIG    = 2'h2;
endpackage

// ### sadc_ramp_timer.sv
// sadc_ramp_timer: 16-bit ramp timer with load port and rollover pulse.
// assumes load and run come from logic on sys_clk.
`timescale 1ns/1ns
module sadc_ramp_timer (
    input  wire logic                     sys_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     run,
    input  wire logic                     load,
    input  wire logic [sadc_pkg::TMR_W-1:0] load_value,
    output logic      [sadc_pkg::TMR_W-1:0] count,
    output logic                          rollover
);
    logic [sadc_pkg::TMR_W-1:0] count_q;
    logic [sadc_pkg::TMR_W-1:0] count_d;
    logic                       roll_q;
    logic                       roll_d;

    always_comb begin
        count_d = count_q;
        roll_d  = 1'b0;
        if (load) begin
            count_d = load_value;
        end else if (run) begin
            // keeps counting after rollover
            count_d = count_q + 1'b1;
            roll_d  = &count_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count_q <= '0;
            roll_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            roll_q  <= roll_d;
        end
    end

    assign count    = count_q;
    assign rollover = roll_q;
endmodule

// ### sadc_control.sv
// sadc_control: register file and control outputs of a slope converter.
// assumes an apb master on sys_clk; comparator arrives asynchronously.
//
// Notes on behaviour
// - all three control registers are readable and writable over the bus.
// - input select in bits 7-4 picks inputs or the three references.
// - bit 3 of channel control reads as zero.
// - mux output bit drives the selector output onto input pin 0.
// - ramp hold stops the timer and discharges the capacitor; resets to one.
// - zero select zeroes inputs 1 and 5 instead of sampling them.
// - step code 0 turns sources off; each code adds 2.25 microamps.
// - two 2-bit fields make 0, 1, 2 or 4 pins of a group digital.
// - reset forces every shared pin to analog input.
// - bit 6 of power control reads as zero.
// - reference power down bit turns voltage references off.
// - sleep oscillator disable stops the oscillator while sleeping.
// - converter power down bit turns the slope converter off.
// - timer counts each cycle while running; reset clears it.
// - comparator fall captures count and sets flag, once per cycle.
// - timer rollover sets overflow flag; counting continues.
`timescale 1ns/1ns
module sadc_control (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // analog side
    input  wire logic        comparator_out,
    input  wire logic        sleep_mode,
    output logic [3:0]       input_select,
    output logic [15:0]      analog_selector,
    output logic             bandgap_selected,
    output logic             upper_slope_reference,
    output logic             lower_slope_reference,
    output logic             mux_pin_output_enable,
    output logic             ramp_hold,
    output logic             ramp_capacitor_node,
    output logic             zero_select,
    output logic [3:0]       current_step_select,
    output logic             current_source_enable,
    output logic [7:0]       pin_is_digital,
    output logic             reference_power_down,
    output logic             sleep_osc_disable,
    output logic             sleep_osc_stop,
    output logic             converter_power_down,
    output logic             capture_flag,
    output logic             overflow_flag
);
    // one-hot of the selector code
    function automatic logic [15:0] onehot16(input logic [3:0] code);
        logic [15:0] r;
        r = 16'h0000;
        r[code] = 1'b1;
        return r;
    endfunction

    // digital mask of four pins; the last pin goes digital first
    function automatic logic [3:0] kind4(input logic [1:0] k);
        logic [3:0] r;
        case (k)
            sadc_pkg::KIND_ALL_ANALOG: r = 4'h0;
            sadc_pkg::KIND_ONE_DIG:    r = 4'h8;
            sadc_pkg::KIND_TWO_DIG:    r = 4'hc;
            default:                   r = 4'hf;
        endcase
        return r;
    endfunction

    // register state
    logic [7:0]  chan_q;
    logic [7:0]  chan_d;
    logic [7:0]  src_q;
    logic [7:0]  src_d;
    logic [7:0]  pwr_q;
    logic [7:0]  pwr_d;
    logic [7:0]  tmr_hi_q;
    logic [7:0]  tmr_hi_d;
    logic        hi_seen_q;
    logic        hi_seen_d;
    logic        order_ok_q;
    logic        order_ok_d;
    logic [15:0] cap_q;
    logic [15:0] cap_d;
    logic        capf_q;
    logic        capf_d;
    logic        ovff_q;
    logic        ovff_d;
    logic        armed_q;
    logic        armed_d;
    // apb answer
    logic        ready_q;
    logic        ready_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        err_q;
    logic        err_d;
    // comparator synchroniser
    logic        cmp_s1_q;
    logic        cmp_s2_q;
    logic        cmp_s3_q;
    logic        cmp_q;
    logic        cmp_d;
    logic        cmp_fall;

    logic        access;
    logic        wr_en;
    logic        hit;
    logic        tmr_load;
    logic        tmr_run;
    logic [15:0] tmr_count;
    logic        tmr_roll;
    logic [7:0]  wbyte;

    assign access = psel & penable;
    // a write lands on the edge where the master sees pready high
    assign wr_en  = access & ready_q & pwrite & ~err_q;
    assign wbyte  = pwdata[7:0];

    always_comb begin
        case (paddr)
            sadc_pkg::OFF_CHAN,
            sadc_pkg::OFF_SRC,
            sadc_pkg::OFF_PWR,
            sadc_pkg::OFF_TMR_H,
            sadc_pkg::OFF_TMR_L,
            sadc_pkg::OFF_CAP,
            sadc_pkg::OFF_STAT: hit = 1'b1;
            default:            hit = 1'b0;
        endcase
    end

    // apb: one wait state so read data comes from a flop
    always_comb begin
        ready_d = access & ~ready_q;
        err_d   = err_q;
        rdata_d = rdata_q;
        if (access & ~ready_q) begin
            err_d   = ~hit;
            rdata_d = 32'h0000_0000;
            case (paddr)
                sadc_pkg::OFF_CHAN:
                    rdata_d[7:0] = chan_q & sadc_pkg::CHAN_RMASK;
                sadc_pkg::OFF_SRC:
                    rdata_d[7:0] = src_q;
                sadc_pkg::OFF_PWR:
                    rdata_d[7:0] = pwr_q & sadc_pkg::PWR_RMASK;
                sadc_pkg::OFF_TMR_H:
                    rdata_d[7:0] = tmr_count[15:8];
                sadc_pkg::OFF_TMR_L:
                    rdata_d[7:0] = tmr_count[7:0];
                sadc_pkg::OFF_CAP:
                    rdata_d[15:0] = cap_q;
                sadc_pkg::OFF_STAT: begin
                    rdata_d[sadc_pkg::CAPF_B] = capf_q;
                    rdata_d[sadc_pkg::OVFF_B] = ovff_q;
                end
                default:
                    rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ready_q <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ready_q <= ready_d;
            err_q   <= err_d;
            rdata_q <= rdata_d;
        end
    end

    // control registers
    always_comb begin
        chan_d     = chan_q;
        src_d      = src_q;
        pwr_d      = pwr_q;
        tmr_hi_d   = tmr_hi_q;
        hi_seen_d  = hi_seen_q;
        order_ok_d = order_ok_q;
        tmr_load   = 1'b0;
        if (wr_en) begin
            case (paddr)
                sadc_pkg::OFF_CHAN:
                    chan_d = wbyte & sadc_pkg::CHAN_RMASK;
                sadc_pkg::OFF_SRC:
                    src_d = wbyte;
                sadc_pkg::OFF_PWR:
                    // reserved bit 6 stored as zero
                    pwr_d = wbyte & sadc_pkg::PWR_RMASK;
                sadc_pkg::OFF_TMR_H: begin
                    tmr_hi_d  = wbyte;
                    hi_seen_d = 1'b1;
                end
                sadc_pkg::OFF_TMR_L: begin
                    // low byte without a high byte first stalls the timer
                    tmr_load   = 1'b1;
                    order_ok_d = hi_seen_q;
                    hi_seen_d  = 1'b0;
                end
                default: begin
                    chan_d = chan_q;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            chan_q     <= sadc_pkg::CHAN_RST;
            src_q      <= sadc_pkg::SRC_RST;
            pwr_q      <= sadc_pkg::PWR_RST;
            tmr_hi_q   <= 8'h00;
            hi_seen_q  <= 1'b0;
            order_ok_q <= 1'b1;
        end else begin
            chan_q     <= chan_d;
            src_q      <= src_d;
            pwr_q      <= pwr_d;
            tmr_hi_q   <= tmr_hi_d;
            hi_seen_q  <= hi_seen_d;
            order_ok_q <= order_ok_d;
        end
    end

    // comparator: a change counts once stages two and three agree
    always_comb begin
        cmp_d = cmp_q;
        if (cmp_s2_q == cmp_s3_q) begin
            cmp_d = cmp_s3_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cmp_s1_q <= 1'b1;
            cmp_s2_q <= 1'b1;
            cmp_s3_q <= 1'b1;
            cmp_q    <= 1'b1;
        end else begin
            cmp_s1_q <= comparator_out;
            cmp_s2_q <= cmp_s1_q;
            cmp_s3_q <= cmp_s2_q;
            cmp_q    <= cmp_d;
        end
    end

    assign cmp_fall = cmp_q & ~cmp_d;

    // timer runs only with hold low, converter powered, clock present
    assign tmr_run = ~chan_q[sadc_pkg::HOLD_B]
                   & ~pwr_q[sadc_pkg::CONVPD_B]
                   & ~sleep_osc_stop
                   & order_ok_q;

    sadc_ramp_timer u_timer (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .run        (tmr_run),
        .load       (tmr_load),
        .load_value ({tmr_hi_q, wbyte}),
        .count      (tmr_count),
        .rollover   (tmr_roll)
    );

    // capture and flags; a set in the clearing cycle wins
    always_comb begin
        cap_d   = cap_q;
        capf_d  = capf_q;
        ovff_d  = ovff_q;
        armed_d = armed_q;
        if (chan_q[sadc_pkg::HOLD_B]) begin
            // hold marks the start of a new conversion cycle
            armed_d = 1'b1;
        end
        if (wr_en && paddr == sadc_pkg::OFF_STAT) begin
            if (wbyte[sadc_pkg::CAPF_B]) begin
                capf_d = 1'b0;
            end
            if (wbyte[sadc_pkg::OVFF_B]) begin
                ovff_d = 1'b0;
            end
        end
        if (cmp_fall && armed_q && tmr_run) begin
            cap_d   = tmr_count;
            capf_d  = 1'b1;
            armed_d = 1'b0;
        end
        if (tmr_roll) begin
            ovff_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cap_q   <= 16'h0000;
            capf_q  <= 1'b0;
            ovff_q  <= 1'b0;
            armed_q <= 1'b1;
        end else begin
            cap_q   <= cap_d;
            capf_q  <= capf_d;
            ovff_q  <= ovff_d;
            armed_q <= armed_d;
        end
    end

    // outputs decoded from the register flops and sleep_mode
    assign pready  = ready_q;
    assign prdata  = rdata_q;
    assign pslverr = err_q & ready_q;

    assign input_select     = chan_q[sadc_pkg::SEL_LSB +: 4];
    // reserved codes are passed as is; software must avoid them
    assign analog_selector  = onehot16(input_select);
    assign bandgap_selected = input_select == sadc_pkg::SEL_BANDGAP;
    assign upper_slope_reference =
        input_select == sadc_pkg::SEL_UPPER;
    assign lower_slope_reference =
        input_select == sadc_pkg::SEL_LOWER;
    // overrides the pin direction setting of input pin 0
    assign mux_pin_output_enable = chan_q[sadc_pkg::MUXOE_B];
    assign ramp_hold             = chan_q[sadc_pkg::HOLD_B];
    assign ramp_capacitor_node   = chan_q[sadc_pkg::HOLD_B];
    assign zero_select           = chan_q[sadc_pkg::ZERO_B];

    assign current_step_select   = src_q[sadc_pkg::STEP_LSB +: 4];
    assign current_source_enable =
        current_step_select != sadc_pkg::STEP_OFF;
    assign pin_is_digital = {kind4(src_q[sadc_pkg::HIGRP_LSB +: 2]),
                             kind4(src_q[sadc_pkg::LOGRP_LSB +: 2])};

    assign reference_power_down = pwr_q[sadc_pkg::REFPD_B];
    assign sleep_osc_disable    = pwr_q[sadc_pkg::OSCD_B];
    assign sleep_osc_stop       = sleep_mode & sleep_osc_disable;
    assign converter_power_down = pwr_q[sadc_pkg::CONVPD_B];

    assign capture_flag  = capf_q;
    assign overflow_flag = ovff_q;
endmodule

// ### sadc_control_asserts.sv
// sadc_control_asserts: port checks of the slope converter control.
// assumes a bind onto sadc_control; one clock, sync reset.
`timescale 1ns/1ns
module sadc_control_asserts (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic [3:0]  input_select,
    input wire logic [15:0] analog_selector,
    input wire logic        bandgap_selected,
    input wire logic        ramp_hold,
    input wire logic [3:0]  current_step_select,
    input wire logic        current_source_enable,
    input wire logic [7:0]  pin_is_digital,
    input wire logic        reference_power_down,
    input wire logic        sleep_mode,
    input wire logic        sleep_osc_disable,
    input wire logic        sleep_osc_stop,
    input wire logic        converter_power_down
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_sel_onehot: assert property (
        analog_selector == (16'h0001 << input_select))
        else $error("selector not one-hot of select field");
    a_bandgap_code: assert property (
        bandgap_selected == (input_select == sadc_pkg::SEL_BANDGAP))
        else $error("bandgap flag wrong for select code");
    a_step_enable: assert property (
        current_source_enable == (current_step_select != 4'h0))
        else $error("source enable wrong for step code");
    a_osc_stop: assert property (
        sleep_osc_stop == (sleep_mode && sleep_osc_disable))
        else $error("sleep oscillator stop wrong");
    a_one_wait: assert property (
        psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("ready not in second access cycle");
    a_ready_access: assert property (
        pready |-> psel && penable && $past(penable))
        else $error("ready outside access phase");
    a_err_nodata: assert property (
        pslverr |-> pready && prdata == 32'h0)
        else $error("error response carries data");
    a_reset_state: assert property (
        $past(sys_rst) |-> ramp_hold && reference_power_down
            && sleep_osc_disable && converter_power_down
            && pin_is_digital == 8'h00)
        else $error("control outputs not at reset state");
    a_pin_kind: assert property (
        pin_is_digital[3:0] inside {4'h0, 4'h8, 4'hc, 4'hf}
        && pin_is_digital[7:4] inside {4'h0, 4'h8, 4'hc, 4'hf})
        else $error("pin kind pattern not allowed");
endmodule

// ### sadc_ramp_model.sv
// sadc_ramp_model: ramp capacitor and comparator on the analog side.
// assumes hold and power down come from the control block.
`timescale 1ns/1ns
module sadc_ramp_model #(
    parameter int TRIP = 6
) (
    input  wire logic sys_clk,
    input  wire logic ramp_hold,
    input  wire logic converter_power_down,
    output logic      comparator_out
);
    logic [7:0] ramp_q = 8'h00;
    // held or unpowered: capacitor discharged
    always @(posedge sys_clk) begin
        if (ramp_hold || converter_power_down) begin
            ramp_q <= 8'h00;
        end else if (ramp_q != 8'hff) begin
            ramp_q <= ramp_q + 8'h01;
        end
    end
    // falls once ramp passes the input level, stays low until discharge
    assign comparator_out = (ramp_q < 8'(TRIP));
endmodule

// ### sadc_control_tb.sv
// sadc_control_tb: register and conversion tests over apb.
// assumes sadc_control, sadc_ramp_model and the checker are compiled.
`timescale 1ns/1ns
module sadc_control_tb;
    logic        sys_clk, sys_rst, psel, penable, pwrite, e;
    logic [7:0]  paddr, pin_is_digital;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, comparator_out, sleep_mode;
    logic [3:0]  input_select, current_step_select;
    logic [15:0] analog_selector;
    logic        bandgap_selected, upper_slope_reference;
    logic        lower_slope_reference, mux_pin_output_enable;
    logic        ramp_hold, ramp_capacitor_node, zero_select;
    logic        current_source_enable, reference_power_down;
    logic        sleep_osc_disable, sleep_osc_stop, converter_power_down;
    logic        capture_flag, overflow_flag;
    int          err_count, n_tests, cyc;

    sadc_control sadc_control_inst (.sys_clk, .sys_rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .comparator_out, .sleep_mode, .input_select, .analog_selector,
        .bandgap_selected, .upper_slope_reference, .lower_slope_reference,
        .mux_pin_output_enable, .ramp_hold, .ramp_capacitor_node,
        .zero_select, .current_step_select, .current_source_enable,
        .pin_is_digital, .reference_power_down, .sleep_osc_disable,
        .sleep_osc_stop, .converter_power_down, .capture_flag,
        .overflow_flag);
    sadc_ramp_model #(.TRIP(6)) sadc_ramp_model_inst (.sys_clk,
        .ramp_hold, .converter_power_down, .comparator_out);

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    function automatic logic [3:0] kind4(input logic [1:0] k);
        return (k == 2'h0) ? 4'h0 : (k == 2'h1) ? 4'h8 :
               (k == 2'h2) ? 4'hc : 4'hf;
    endfunction

    task chk_word(input string n, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask
    task chk_bit(input string n, input logic x, input logic g);
        chk_word(n, {31'h0, x}, {31'h0, g});
    endtask

    task close_out;
        $display("mismatches %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one full transfer; returns an edge after release so calls chain
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no assumed wait count: only the bench ceiling ends a stall
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk_word($sformatf("reg %h", a), x, r);
    endtask
    task do_reset;
        sys_rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
    endtask

    // ceiling well above the few hundred cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            close_out;
        end
    end

    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sleep_mode = 1'b0;
        err_count = 0;
        n_tests = 0;
        cyc = 0;
        do_reset;
        rd(sadc_pkg::OFF_CHAN, 32'h02);
        rd(sadc_pkg::OFF_SRC, 32'h00);
        rd(sadc_pkg::OFF_PWR, 32'h3f);
        rd(sadc_pkg::OFF_TMR_L, 32'h00);
        chk_bit("hold", 1'b1, ramp_hold);
        chk_word("pins", 32'h0, {24'h0, pin_is_digital});
        wr(sadc_pkg::OFF_CHAN, 32'hff);
        rd(sadc_pkg::OFF_CHAN, 32'hf7);
        chk_bit("mux out", 1'b1, mux_pin_output_enable);
        chk_bit("zero", 1'b1, zero_select);
        chk_bit("cap node", 1'b1, ramp_capacitor_node);
        wr(sadc_pkg::OFF_PWR, 32'h69);
        rd(sadc_pkg::OFF_PWR, 32'h29);
        wr(8'h1c, 32'h5a);
        chk_bit("slverr", 1'b1, e);
        rd(8'h1c, 32'h0);
        for (int i = 0; i < 16; i++) begin
            wr(sadc_pkg::OFF_CHAN, {24'h0, i[3:0], 4'h0});
            chk_word("select", i, {28'h0, input_select});
            chk_word("mux", 1 << i, {16'h0, analog_selector});
            chk_bit("bandgap", i == 4, bandgap_selected);
            chk_bit("upper", i == 5, upper_slope_reference);
            chk_bit("lower", i == 6, lower_slope_reference);
            wr(sadc_pkg::OFF_SRC, {24'h0, i[3:0], i[1:0], i[3:2]});
            chk_word("step", i, {28'h0, current_step_select});
            chk_bit("src on", i != 0, current_source_enable);
            chk_word("kinds", {kind4(i[1:0]), kind4(i[3:2])},
                {24'h0, pin_is_digital});
        end
        wr(sadc_pkg::OFF_PWR, 32'h00);
        chk_bit("ref pd", 1'b0, reference_power_down);
        chk_bit("osc dis", 1'b0, sleep_osc_disable);
        chk_bit("conv pd", 1'b0, converter_power_down);
        sleep_mode <= 1'b1;
        wr(sadc_pkg::OFF_PWR, 32'h08);
        chk_bit("osc stop", 1'b1, sleep_osc_stop);
        sleep_mode <= 1'b0;
        wr(sadc_pkg::OFF_PWR, 32'h21);
        chk_bit("osc stop", 1'b0, sleep_osc_stop);
        chk_bit("ref pd", 1'b1, reference_power_down);
        chk_bit("conv pd", 1'b1, converter_power_down);
        wr(sadc_pkg::OFF_PWR, 32'h00);
        wr(sadc_pkg::OFF_CHAN, 32'h02);
        wr(sadc_pkg::OFF_STAT, 32'h03);
        wr(sadc_pkg::OFF_TMR_H, 32'hff);
        wr(sadc_pkg::OFF_TMR_L, 32'hf0);
        wr(sadc_pkg::OFF_CHAN, 32'h00);
        for (int k = 0; k < 60 && overflow_flag !== 1'b1; k++) begin
            @(posedge sys_clk);
        end
        chk_bit("overflow", 1'b1, overflow_flag);
        chk_bit("capture", 1'b1, capture_flag);
        apb(1'b0, sadc_pkg::OFF_CAP, 32'h0);
        chk_bit("cap window", 1'b1, r > 32'hfff0 && r <= 32'hffff);
        rd(sadc_pkg::OFF_STAT, 32'h03);
        wr(sadc_pkg::OFF_STAT, 32'h03);
        rd(sadc_pkg::OFF_STAT, 32'h00);
        apb(1'b0, sadc_pkg::OFF_TMR_L, 32'h0);
        chk_bit("runs on", 1'b1, r != 32'h0 && r < 32'h80);
        // low byte alone must leave the timer stopped
        wr(sadc_pkg::OFF_CHAN, 32'h02);
        wr(sadc_pkg::OFF_TMR_L, 32'h20);
        wr(sadc_pkg::OFF_CHAN, 32'h00);
        repeat (10) @(posedge sys_clk);
        rd(sadc_pkg::OFF_TMR_L, 32'h20);
        do_reset;
        rd(sadc_pkg::OFF_CHAN, 32'h02);
        rd(sadc_pkg::OFF_TMR_L, 32'h00);
        close_out;
    end
endmodule

bind sadc_control sadc_control_asserts sadc_control_asserts_inst (
    .sys_clk, .sys_rst, .psel, .penable, .pready, .pslverr, .prdata,
    .input_select, .analog_selector, .bandgap_selected, .ramp_hold,
    .current_step_select, .current_source_enable, .pin_is_digital,
    .reference_power_down, .sleep_mode, .sleep_osc_disable,
    .sleep_osc_stop, .converter_power_down);
